// [verilog/tncp_pkg.sv]
// Constants shared by the 16-bit timer/counter design and its bench
package tncp_pkg;
	localparam int CNT_W = 16;
	localparam int CTRL_W = 15;
	localparam int FLAG_W = 4;
	localparam int PSC_SEL_W = 3;
	localparam int NUM_CH = 2;

	// Count limits and fixed TOP values
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] CNT_BOTTOM = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] TOP_8BIT = 16'h00FF;
	localparam logic [15:0] TOP_9BIT = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;

	// Waveform mode codes
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_CTC_CMPA = 4'h4;
	localparam logic [3:0] MODE_FAST_8 = 4'h5;
	localparam logic [3:0] MODE_FAST_9 = 4'h6;
	localparam logic [3:0] MODE_FAST_10 = 4'h7;
	localparam logic [3:0] MODE_CTC_CAPT = 4'hC;
	localparam logic [3:0] MODE_FAST_CAPT = 4'hE;
	localparam logic [3:0] MODE_FAST_CMPA = 4'hF;

	// Output action codes
	localparam logic [1:0] ACT_OFF = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;

	// Prescaler selection and ratios
	localparam logic [2:0] PSC_STOP = 3'h0;
	localparam logic [2:0] PSC_DIV1 = 3'h1;
	localparam logic [2:0] PSC_DIV8 = 3'h2;
	localparam logic [2:0] PSC_DIV64 = 3'h3;
	localparam logic [2:0] PSC_DIV256 = 3'h4;
	localparam logic [2:0] PSC_DIV1024 = 3'h5;
	localparam logic [10:0] RATIO_1 = 11'h001;
	localparam logic [10:0] RATIO_8 = 11'h008;
	localparam logic [10:0] RATIO_64 = 11'h040;
	localparam logic [10:0] RATIO_256 = 11'h100;
	localparam logic [10:0] RATIO_1024 = 11'h400;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_COUNT = 8'h04;
	localparam logic [7:0] REG_CMP_A = 8'h08;
	localparam logic [7:0] REG_CMP_B = 8'h0C;
	localparam logic [7:0] REG_CAPT = 8'h10;
	localparam logic [7:0] REG_FLAGS = 8'h14;

	// Control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_ACT_LSB = 4;
	localparam int CTRL_PSC_LSB = 8;
	localparam int CTRL_DIR_LSB = 11;
	localparam int CTRL_PORT_LSB = 13;
	localparam logic [14:0] CTRL_RST = 15'h0000;

	// Flag register bits
	localparam int FLG_WRAP = 0;
	localparam int FLG_MATCH_A = 1;
	localparam int FLG_MATCH_B = 2;
	localparam int FLG_CAPT = 3;
	localparam logic [3:0] FLAGS_RST = 4'h0;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;
endpackage

// [verilog/tncp_timer.sv]
// 16-bit timer/counter with normal, clear-on-match and fast PWM modes, AHB-Lite slave
// Contract
// RULE1: normal mode counts up, wraps 0xFFFF to zero
// RULE2: normal wrap flag set as count becomes zero
// RULE3: wrap flag cleared when overflow is serviced
// RULE4: normal mode count writes take effect immediately
// RULE5: clear-on-match clears at compare A or capture
// RULE6: clear-on-match sets flag of TOP register
// RULE7: clear-on-match TOP unbuffered; missed TOP wraps first
// RULE8: clear-on-match action 1 toggles, pin needs direction
// RULE9: clear-on-match sets wrap flag at max-to-zero
// RULE10: fast PWM counts zero to TOP, restarts
// RULE11: fast PWM TOP per mode; clears after TOP
// RULE12: fast PWM action 2/3 clear/set polarity
// RULE13: fast PWM wrap and TOP flag at TOP
// RULE14: each channel flags its own compare match
// RULE15: fast PWM compare A buffered, loads at TOP
// RULE16: fast PWM capture TOP unbuffered; missed TOP wraps
// RULE17: fixed TOP masks high compare bits on write
// RULE18: software keeps TOP at or above compares
// RULE19: compare zero spikes, compare TOP gives constant
// RULE20: fast PWM toggle on A only in mode 15
// RULE21: software register TOP at least three
// RULE22: timer clock is prescaled by 1/8/64/256/1024
// RULE23: action zero leaves normal port operation
// RULE24: compare equal TOP: match ignored, bottom action
// RULE25: four-bit mode field; other codes hold counter
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps

module tncp_timer
	import tncp_pkg::*;
#(
	parameter int PSC_W = 10
)
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// AHB-Lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// Interrupt controller side
	input wire logic wrap_service_ack_in,
	output logic wrap_flag_out,
	output logic match_flag_a_out,
	output logic match_flag_b_out,
	output logic capture_flag_out,
	// Waveform pins, channel 0 is A and 1 is B
	output logic [NUM_CH-1:0] pin_data_out,
	output logic [NUM_CH-1:0] pin_oe_out
);

	if (PSC_W < 10)
	begin : g_psc_check
		$error("PSC_W must hold a count of 1023");
	end

	// Mode decoding helpers
	function automatic logic is_fast(input logic [3:0] m);
		return m == MODE_FAST_8 || m == MODE_FAST_9 || m == MODE_FAST_10 ||
			m == MODE_FAST_CAPT || m == MODE_FAST_CMPA;
	endfunction

	function automatic logic is_ctc(input logic [3:0] m);
		return m == MODE_CTC_CMPA || m == MODE_CTC_CAPT;
	endfunction

	function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] cmp_a,
		input logic [15:0] capt);
		logic [15:0] t;
		t = CNT_MAX;
		unique case (m)
			MODE_CTC_CMPA, MODE_FAST_CMPA: t = cmp_a;
			MODE_CTC_CAPT, MODE_FAST_CAPT: t = capt;
			MODE_FAST_8: t = TOP_8BIT;
			MODE_FAST_9: t = TOP_9BIT;
			MODE_FAST_10: t = TOP_10BIT;
			default: t = CNT_MAX;
		endcase
		return t;
	endfunction

	function automatic logic [15:0] cmp_mask(input logic [3:0] m);
		logic [15:0] k;
		k = CNT_MAX;
		unique case (m)
			MODE_FAST_8: k = TOP_8BIT;
			MODE_FAST_9: k = TOP_9BIT;
			MODE_FAST_10: k = TOP_10BIT;
			default: k = CNT_MAX;
		endcase
		return k;
	endfunction

	function automatic logic [10:0] ratio_of(input logic [2:0] s);
		logic [10:0] r;
		r = RATIO_1;
		unique case (s)
			PSC_DIV8: r = RATIO_8;
			PSC_DIV64: r = RATIO_64;
			PSC_DIV256: r = RATIO_256;
			PSC_DIV1024: r = RATIO_1024;
			default: r = RATIO_1;
		endcase
		return r;
	endfunction

	// Toggle in fast PWM only for channel A in mode 15
	function automatic logic toggle_ok(input logic [3:0] m, input logic ch_a);
		return !is_fast(m) || (ch_a && m == MODE_FAST_CMPA);
	endfunction

	function automatic logic wave_next(input logic [3:0] m, input logic [1:0] act,
		input logic ch_a, input logic q, input logic match, input logic bottom);
		logic n;
		n = q;
		if (is_fast(m))
		begin
			unique case (act)
				ACT_TOGGLE: n = (match && toggle_ok(m, ch_a)) ? !q : q; // RULE20
				ACT_CLEAR: n = bottom ? 1'b1 : (match ? 1'b0 : q); // RULE12 RULE24
				ACT_SET: n = bottom ? 1'b0 : (match ? 1'b1 : q); // RULE12 RULE24
				default: n = q;
			endcase
		end
		else if (match)
		begin
			unique case (act)
				ACT_TOGGLE: n = !q; // RULE8
				ACT_CLEAR: n = 1'b0;
				ACT_SET: n = 1'b1;
				default: n = q;
			endcase
		end
		return n;
	endfunction

	// Bus state
	logic bus_wr_q;
	logic bus_rd_q;
	logic [7:0] addr_q;
	logic ready_q;
	logic [31:0] rdata_q;
	logic resp_q;

	// Block state
	logic [CTRL_W-1:0] ctrl_q;
	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] capt_q;
	logic [FLAG_W-1:0] flags_q;
	logic [PSC_W-1:0] psc_q;
	logic [CNT_W-1:0] cmp_buf_q [NUM_CH];
	logic [CNT_W-1:0] cmp_act_q [NUM_CH];
	logic [NUM_CH-1:0] wave_q;
	logic [NUM_CH-1:0] pin_q;
	logic [NUM_CH-1:0] oe_q;

	// Address phase capture and register strobes
	wire addr_go = hsel_in && hready_in && htrans_in == HTRANS_NONSEQ;
	wire wr_ctrl = bus_wr_q && addr_q == REG_CTRL;
	wire wr_count = bus_wr_q && addr_q == REG_COUNT;
	wire wr_capt = bus_wr_q && addr_q == REG_CAPT;
	wire wr_flags = bus_wr_q && addr_q == REG_FLAGS;
	wire [NUM_CH-1:0] wr_cmp = {bus_wr_q && addr_q == REG_CMP_B,
		bus_wr_q && addr_q == REG_CMP_A};

	// Control fields
	wire [3:0] mode = ctrl_q[CTRL_MODE_LSB +: 4];
	wire [2:0] psc_sel = ctrl_q[CTRL_PSC_LSB +: PSC_SEL_W];
	wire mode_fast = is_fast(mode);
	wire mode_ctc = is_ctc(mode);
	wire mode_normal = mode == MODE_NORMAL;
	wire mode_run = mode_fast || mode_ctc || mode_normal; // RULE25

	// Prescaler
	wire [PSC_W-1:0] psc_last = PSC_W'(ratio_of(psc_sel) - RATIO_1);
	wire tick = psc_sel != PSC_STOP && psc_q == psc_last; // RULE22
	wire step = tick && mode_run;

	// Counter sequencing
	wire [CNT_W-1:0] top_val = top_of(mode, cmp_act_q[0], capt_q); // RULE5 RULE11
	wire at_top = count_q == top_val;
	wire clear_at_top = (mode_fast || mode_ctc) && at_top; // RULE5 RULE10 RULE11
	wire [CNT_W-1:0] count_inc = CNT_W'(count_q + CNT_ONE); // RULE1 RULE7 RULE16
	wire [CNT_W-1:0] count_d = wr_count ? hwdata_in[CNT_W-1:0] : // RULE4
		(step ? (clear_at_top ? CNT_BOTTOM : count_inc) : count_q);
	wire bottom = step && mode_fast && at_top;
	wire [CNT_W-1:0] cmp_wval = hwdata_in[CNT_W-1:0] & cmp_mask(mode); // RULE17

	// Flag events, set wins over clear
	wire set_wrap = step && (mode_fast ? at_top : count_q == CNT_MAX); // RULE2 RULE9 RULE13
	wire capt_top = mode == MODE_CTC_CAPT || mode == MODE_FAST_CAPT;
	wire set_capt = step && at_top && capt_top; // RULE6 RULE13
	wire [NUM_CH-1:0] match;
	wire [FLAG_W-1:0] flag_set = {set_capt, match[1], match[0], set_wrap};
	wire [FLAG_W-1:0] flag_clr = (wr_flags ? hwdata_in[FLAG_W-1:0] : FLAGS_RST) |
		(FLAG_W'(wrap_service_ack_in) << FLG_WRAP); // RULE3
	wire [FLAG_W-1:0] flags_d = (flags_q & ~flag_clr) | flag_set;

	// Read data selection
	wire [31:0] rd_mux =
		addr_q == REG_CTRL ? {{(32 - CTRL_W){1'b0}}, ctrl_q} :
		addr_q == REG_COUNT ? {{(32 - CNT_W){1'b0}}, count_q} :
		addr_q == REG_CMP_A ? {{(32 - CNT_W){1'b0}}, cmp_buf_q[0]} :
		addr_q == REG_CMP_B ? {{(32 - CNT_W){1'b0}}, cmp_buf_q[1]} :
		addr_q == REG_CAPT ? {{(32 - CNT_W){1'b0}}, capt_q} :
		addr_q == REG_FLAGS ? {{(32 - FLAG_W){1'b0}}, flags_q} :
		RDATA_RST;

	// Bus phases: writes take no wait, reads take one
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			bus_wr_q <= 1'b0;
			bus_rd_q <= 1'b0;
			addr_q <= REG_CTRL;
			ready_q <= 1'b1;
			rdata_q <= RDATA_RST;
			resp_q <= HRESP_OKAY;
		end
		else
		begin
			bus_wr_q <= addr_go && hwrite_in;
			bus_rd_q <= addr_go && !hwrite_in;
			if (addr_go)
				addr_q <= haddr_in[7:0];
			ready_q <= !(addr_go && !hwrite_in);
			if (bus_rd_q)
				rdata_q <= rd_mux;
			resp_q <= HRESP_OKAY;
		end
	end

	// Control, counter, capture, flags, prescaler
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			ctrl_q <= CTRL_RST;
			count_q <= CNT_BOTTOM;
			capt_q <= CNT_BOTTOM;
			flags_q <= FLAGS_RST;
			psc_q <= '0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= hwdata_in[CTRL_W-1:0];
			count_q <= count_d;
			if (wr_capt)
				capt_q <= hwdata_in[CNT_W-1:0]; // RULE7 RULE16
			flags_q <= flags_d;
			psc_q <= (tick || psc_sel == PSC_STOP) ? '0 : PSC_W'(psc_q + 1'b1);
		end
	end

	// Compare channels and waveform outputs
	for (genvar i = 0; i < NUM_CH; i++)
	begin : g_ch
		wire [1:0] act = ctrl_q[CTRL_ACT_LSB + 2 * i +: 2];
		wire dir_out = ctrl_q[CTRL_DIR_LSB + i];
		wire port_bit = ctrl_q[CTRL_PORT_LSB + i];
		wire ch_a = i == 0;
		wire connected = act != ACT_OFF && (act != ACT_TOGGLE || toggle_ok(mode, ch_a)); // RULE23
		wire wave_d = wave_next(mode, act, ch_a, wave_q[i], match[i], bottom);
		wire [CNT_W-1:0] cmp_next = (wr_cmp[i] && !mode_fast) ? cmp_wval : // RULE7
			(bottom ? cmp_buf_q[i] : cmp_act_q[i]); // RULE15

		assign match[i] = step && count_q == cmp_act_q[i]; // RULE14 RULE19

		always_ff @(posedge clk_in)
		begin
			if (reset_in)
			begin
				cmp_buf_q[i] <= CNT_BOTTOM;
				cmp_act_q[i] <= CNT_BOTTOM;
				wave_q[i] <= 1'b0;
				pin_q[i] <= 1'b0;
				oe_q[i] <= 1'b0;
			end
			else
			begin
				if (wr_cmp[i])
					cmp_buf_q[i] <= cmp_wval; // RULE15 RULE17
				cmp_act_q[i] <= cmp_next;
				wave_q[i] <= wave_d;
				pin_q[i] <= connected ? wave_d : port_bit; // RULE8 RULE23
				oe_q[i] <= dir_out; // RULE8
			end
		end
	end

	assign hrdata_out = rdata_q;
	assign hreadyout_out = ready_q;
	assign hresp_out = resp_q;
	assign wrap_flag_out = flags_q[FLG_WRAP];
	assign match_flag_a_out = flags_q[FLG_MATCH_A];
	assign match_flag_b_out = flags_q[FLG_MATCH_B];
	assign capture_flag_out = flags_q[FLG_CAPT];
	assign pin_data_out = pin_q;
	assign pin_oe_out = oe_q;

endmodule

// [verif/tncp_sva.sv]
// Port-level assertions for the timer block
`timescale 1ns/10ps
module tncp_sva
	import tncp_pkg::*;
(
	// Clock, reset and bus
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	input wire logic hreadyout_out,
	input wire logic hresp_out,
	// Flags and pins
	input wire logic wrap_service_ack_in,
	input wire logic wrap_flag_out,
	input wire logic match_flag_a_out,
	input wire logic [NUM_CH-1:0] pin_data_out,
	input wire logic [NUM_CH-1:0] pin_oe_out
);
	wire logic take = hsel_in && hready_in && htrans_in == HTRANS_NONSEQ;
	logic cw_q;
	logic fw_q;
	logic [14:0] ctrl_q;
	// Shadow of the control register
	always_ff @(posedge clk_in)
	begin
		cw_q <= !reset_in && take && hwrite_in && haddr_in[7:0] == REG_CTRL;
		fw_q <= !reset_in && take && hwrite_in && haddr_in[7:0] == REG_FLAGS;
		ctrl_q <= reset_in ? CTRL_RST : cw_q ? hwdata_in[14:0] : ctrl_q;
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (reset_in);
	property p_okay; hresp_out == HRESP_OKAY; endproperty
	a_okay: assert property (p_okay) else $error("error response");
	property p_rd; take && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out; endproperty
	a_rd: assert property (p_rd) else $error("read wait wrong");
	property p_wr; take && hwrite_in |=> hreadyout_out; endproperty
	a_wr: assert property (p_wr) else $error("write stalled");
	property p_ack; wrap_service_ack_in && ctrl_q[10:8] == PSC_STOP |=> !wrap_flag_out; endproperty
	a_ack: assert property (p_ack) else $error("wrap flag kept");
	property p_stick; $fell(wrap_flag_out) |-> $past(wrap_service_ack_in) || $past(fw_q); endproperty
	a_stick: assert property (p_stick) else $error("wrap flag lost");
	property p_oe; cw_q |-> ##2 pin_oe_out == $past(hwdata_in[12:11], 2); endproperty
	a_oe: assert property (p_oe) else $error("direction wrong");
	property p_port; $stable(ctrl_q)[*3] ##0 ctrl_q[5:4] == ACT_OFF
		|-> pin_data_out[0] == ctrl_q[CTRL_PORT_LSB]; endproperty
	a_port: assert property (p_port) else $error("port level wrong");
	property p_stop; ctrl_q[10:8] == PSC_STOP && $past(ctrl_q[10:8]) == PSC_STOP
		|-> !$rose(wrap_flag_out) && !$rose(match_flag_a_out); endproperty
	a_stop: assert property (p_stop) else $error("flag while stopped");
	property p_hold; ctrl_q[3:0] == 4'hD && $past(ctrl_q[3:0]) == 4'hD
		|-> !$rose(wrap_flag_out) && !$rose(match_flag_a_out); endproperty
	a_hold: assert property (p_hold) else $error("flag in held mode");
endmodule

// [verif/tb_timer16_normal_ctc_fast_pwm.sv]
// Self-checking bench for the 16-bit timer block
`timescale 1ns/10ps
module tb_timer16_normal_ctc_fast_pwm
	import tncp_pkg::*;
;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic hsel_in = 1'b0;
	logic [31:0] haddr_in = 32'h0;
	logic [1:0] htrans_in = 2'h0;
	logic hwrite_in = 1'b0;
	logic [2:0] hsize_in = 3'h2;
	logic [31:0] hwdata_in = 32'h0;
	logic wrap_service_ack_in = 1'b0;
	logic hready_in;
	logic [31:0] hrdata_out;
	logic hreadyout_out, hresp_out, wrap_flag_out;
	logic match_flag_a_out, match_flag_b_out, capture_flag_out;
	logic [NUM_CH-1:0] pin_data_out, pin_oe_out;
	logic rd_dp = 1'b0;
	logic [31:0] exp_q[$];
	int fails = 0;
	int n_checks = 0;
	int seed = 32'hC538FDE6;
	assign hready_in = hreadyout_out;
	always #25 clk_in = ~clk_in;
	tncp_timer DUT (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.hsel_in(hsel_in),
		.haddr_in(haddr_in),
		.htrans_in(htrans_in),
		.hwrite_in(hwrite_in),
		.hsize_in(hsize_in),
		.hwdata_in(hwdata_in),
		.hready_in(hready_in),
		.hrdata_out(hrdata_out),
		.hreadyout_out(hreadyout_out),
		.hresp_out(hresp_out),
		.wrap_service_ack_in(wrap_service_ack_in),
		.wrap_flag_out(wrap_flag_out),
		.match_flag_a_out(match_flag_a_out),
		.match_flag_b_out(match_flag_b_out),
		.capture_flag_out(capture_flag_out),
		.pin_data_out(pin_data_out),
		.pin_oe_out(pin_oe_out)
	);
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Bounded wait on one of four outputs
	task automatic wt(input int s, input logic v, input int lim, output int t);
		for (t = 1; t <= lim; t++)
		begin
			@(posedge clk_in);
			if ((s == 0 ? pin_data_out[0] : s == 1 ? wrap_flag_out :
				s == 2 ? capture_flag_out : hreadyout_out) === v)
				return;
		end
		fails++;
		report_and_stop;
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		int t;
		hsel_in <= 1'b1;
		htrans_in <= HTRANS_NONSEQ;
		haddr_in <= {24'h0, a};
		hwrite_in <= w;
		wt(3, 1'b1, 9, t);
		htrans_in <= 2'h0;
		hwdata_in <= d;
		wt(3, 1'b1, 9, t);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(a, 1'b0, 32'h0);
	endtask
	function automatic logic [31:0] ctl(input logic [3:0] m, input logic [1:0] a,
		input logic [2:0] p);
		return 32'(m) | 32'(a) << CTRL_ACT_LSB | 32'(p) << CTRL_PSC_LSB | 32'h800;
	endfunction
	task automatic meas(input int hi, input int per);
		int t;
		int th;
		int tl;
		repeat (3 * per) @(posedge clk_in);
		wt(0, 1'b0, 2000, t);
		wt(0, 1'b1, 2000, t);
		wt(0, 1'b0, 2000, th);
		wt(0, 1'b1, 2000, tl);
		chk(32'(th), 32'(hi));
		chk(32'(th + tl), 32'(per));
	endtask
	task automatic run(input logic [3:0] m, input logic [1:0] a, input logic [15:0] top,
		input logic [15:0] c, input logic [15:0] cr, input int hi, input int per);
		wr(REG_CTRL, ctl(m, ACT_OFF, PSC_STOP));
		wr(REG_COUNT, 32'h0);
		wr(REG_CAPT, 32'(top));
		wr(REG_CMP_A, 32'(c));
		rd(REG_CMP_A, 32'(cr));
		wr(REG_FLAGS, 32'hF);
		wr(REG_CTRL, ctl(m, a, PSC_DIV1));
		meas(hi, per);
		wr(REG_CTRL, ctl(m, ACT_OFF, PSC_STOP));
		rd(REG_FLAGS, m == MODE_FAST_CAPT ? 32'hF : 32'h7);
		chk(32'({capture_flag_out, match_flag_b_out, match_flag_a_out, wrap_flag_out}),
			m == MODE_FAST_CAPT ? 32'hF : 32'h7);
	endtask
	// Read results come back one wait state after the address phase
	always @(posedge clk_in)
	begin
		if (rd_dp && hreadyout_out === 1'b1)
		begin
			chk(hrdata_out, exp_q.pop_front());
			rd_dp <= 1'b0;
		end
		else if (hsel_in && htrans_in == HTRANS_NONSEQ && !hwrite_in && hreadyout_out)
			rd_dp <= 1'b1;
	end
	initial
	begin
		int i;
		int t;
		logic [31:0] v;
		repeat (4) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		for (i = 0; i < 7; i++)
			rd(8'(4 * i), 32'h0);
		wr(8'h18, 32'hFFFF_FFFF);
		rd(8'h18, 32'h0);
		wr(REG_CTRL, 32'h3 << CTRL_PORT_LSB);
		repeat (2) @(posedge clk_in);
		chk(32'(pin_data_out), 32'h3);
		for (i = 0; i < 4; i++)
		begin
			v = $random(seed);
			wr(REG_COUNT, v);
			rd(REG_COUNT, {16'h0, v[15:0]});
		end
		wr(REG_COUNT, 32'h1234);
		wr(REG_CTRL, ctl(4'hD, ACT_OFF, PSC_DIV1));
		repeat (20) @(posedge clk_in);
		rd(REG_COUNT, 32'h1234);
		wr(REG_CMP_A, 32'hFFF4);
		wr(REG_COUNT, 32'hFFF0);
		wr(REG_CTRL, ctl(MODE_NORMAL, ACT_OFF, PSC_DIV1));
		wt(1, 1'b1, 40, t);
		wr(REG_CTRL, ctl(MODE_NORMAL, ACT_OFF, PSC_STOP));
		rd(REG_FLAGS, 32'h7);
		wrap_service_ack_in <= 1'b1;
		@(posedge clk_in);
		wrap_service_ack_in <= 1'b0;
		rd(REG_FLAGS, 32'h6);
		wr(REG_FLAGS, 32'h6);
		rd(REG_FLAGS, 32'h0);
		wr(REG_COUNT, 32'h0);
		wr(REG_CMP_A, 32'h4);
		wr(REG_CTRL, ctl(MODE_CTC_CMPA, ACT_TOGGLE, PSC_DIV1));
		meas(5, 10);
		wr(REG_CTRL, ctl(MODE_CTC_CMPA, ACT_TOGGLE, PSC_DIV8));
		meas(40, 80);
		wr(REG_CTRL, ctl(MODE_CTC_CMPA, ACT_TOGGLE, PSC_DIV64));
		meas(320, 640);
		wr(REG_CTRL, ctl(MODE_CTC_CMPA, ACT_OFF, PSC_STOP));
		rd(REG_FLAGS, 32'h6);
		wr(REG_COUNT, 32'h20);
		wr(REG_CAPT, 32'h10);
		wr(REG_CTRL, ctl(MODE_CTC_CAPT, ACT_OFF, PSC_DIV1));
		wt(1, 1'b1, 70000, t);
		chk({31'h0, capture_flag_out}, 32'h0);
		wt(2, 1'b1, 40, t);
		run(MODE_FAST_CMPA, ACT_TOGGLE, 16'h0, 16'h3, 16'h3, 4, 8);
		run(MODE_FAST_CAPT, ACT_CLEAR, 16'h7, 16'h2, 16'h2, 3, 8);
		run(MODE_FAST_CAPT, ACT_SET, 16'h7, 16'h2, 16'h2, 5, 8);
		run(MODE_FAST_CAPT, ACT_CLEAR, 16'h7, 16'h0, 16'h0, 1, 8);
		run(MODE_FAST_8, ACT_CLEAR, 16'h0, 16'h1F80, 16'h80, 129, 256);
		run(MODE_FAST_9, ACT_SET, 16'h0, 16'hFF00, 16'h100, 255, 512);
		run(MODE_FAST_10, ACT_CLEAR, 16'h0, 16'h403, 16'h3, 4, 1024);
		report_and_stop;
	end
endmodule
bind tncp_timer tncp_sva u_sva (
	.clk_in(clk_in),
	.reset_in(reset_in),
	.hsel_in(hsel_in),
	.haddr_in(haddr_in),
	.htrans_in(htrans_in),
	.hwrite_in(hwrite_in),
	.hwdata_in(hwdata_in),
	.hready_in(hready_in),
	.hreadyout_out(hreadyout_out),
	.hresp_out(hresp_out),
	.wrap_service_ack_in(wrap_service_ack_in),
	.wrap_flag_out(wrap_flag_out),
	.match_flag_a_out(match_flag_a_out),
	.pin_data_out(pin_data_out),
	.pin_oe_out(pin_oe_out)
);
